// [bench/dmem_model.sv]
// Data memory standing behind the indirect port of the sequencer.
// Assumes combinational read and a one-cycle write strobe on the core clock.
`timescale 1ns/1ps

module dmem_model
(
  input  wire logic       clk_in,          // Core clock
  input  wire logic [8:0] addr_in,         // Nine-bit data address
  input  wire logic [7:0] wdata_in,        // Write data
  input  wire logic       wr_in,           // Write strobe
  output logic      [7:0] rdata_out,       // Combinational read data
  output logic      [7:0] write_count_out  // Writes taken so far
);
  logic [7:0] mem [0:511];
  logic [7:0] count_r = 8'h00;

  // ------------------------------------------------------------------
  // Preload: low address byte mixed with the bank bit
  // ------------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 512; i++)
      mem[i] = 8'(i) ^ {i[8], 7'h2d};
  end

  always @(posedge clk_in)
  begin
    if (wr_in)
    begin
      mem[addr_in] <= wdata_in;
      count_r <= count_r + 8'h01;
    end
  end

  assign rdata_out       = mem[addr_in];
  assign write_count_out = count_r;

endmodule : dmem_model

// [bench/tb_program_counter_stack_indirect.sv]
// Self-checking bench for the program counter, return stack and indirect pointer.
// Assumes the sequencer core, its package and the data memory model.
`timescale 1ns/1ps

module tb_program_counter_stack_indirect;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [7:0]  data;
    logic [12:0] exp;
    logic        err;
  } row_type;

  localparam logic [7:0] a_pcl = pc_stack_pkg::OFS_PCL;
  localparam logic [7:0] a_lat = pc_stack_pkg::OFS_LATCH;
  localparam logic [7:0] a_win = pc_stack_pkg::OFS_WINDOW;
  localparam logic [7:0] a_ptr = pc_stack_pkg::OFS_POINTER;
  localparam logic [7:0] a_bnk = pc_stack_pkg::OFS_BANK;
  localparam logic [4:0] kind_irq  = 5'h10;
  localparam logic [4:0] kind_call = 5'h08;
  localparam logic [4:0] kind_jump = 5'h04;
  localparam logic [4:0] kind_ret  = 5'h02;
  localparam logic [4:0] kind_step = 5'h01;

  // Writes check pc_out afterwards, reads check the read data
  row_type rows [0:19] = '{
    '{1'b0, a_pcl, 8'h00, 13'h0000, 1'b0}, '{1'b0, a_lat, 8'h00, 13'h0000, 1'b0},
    '{1'b0, a_ptr, 8'h00, 13'h0000, 1'b0}, '{1'b0, a_bnk, 8'h00, 13'h0000, 1'b0},
    '{1'b1, a_lat, 8'h15, 13'h0000, 1'b0}, '{1'b1, a_pcl, 8'h34, 13'h1534, 1'b0},
    '{1'b0, a_pcl, 8'h00, 13'h0034, 1'b0}, '{1'b0, a_lat, 8'h00, 13'h0015, 1'b0},
    '{1'b1, a_pcl, 8'h05, 13'h1505, 1'b0}, '{1'b1, a_ptr, 8'h25, 13'h1505, 1'b0},
    '{1'b0, a_win, 8'h00, 13'h0008, 1'b0}, '{1'b1, a_bnk, 8'h01, 13'h1505, 1'b0},
    '{1'b0, a_win, 8'h00, 13'h0088, 1'b0}, '{1'b1, a_win, 8'ha7, 13'h1505, 1'b0},
    '{1'b0, a_win, 8'h00, 13'h00a7, 1'b0}, '{1'b1, a_ptr, 8'h00, 13'h1505, 1'b0},
    '{1'b0, a_win, 8'h00, 13'h0000, 1'b0}, '{1'b1, a_win, 8'h99, 13'h1505, 1'b0},
    '{1'b0, 8'h14, 8'h00, 13'h0000, 1'b1}, '{1'b1, 8'h14, 8'hff, 13'h1505, 1'b1}};

  logic        core_clk_in = 1'b0;
  logic        reset_n_in  = 1'b0;
  logic        psel_in     = 1'b0;
  logic        penable_in  = 1'b0;
  logic        pwrite_in   = 1'b0;
  logic [7:0]  paddr_in    = 8'h00;
  logic [31:0] pwdata_in   = 32'h0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        step_in     = 1'b0;
  logic        call_in     = 1'b0;
  logic        jump_in     = 1'b0;
  logic        return_in   = 1'b0;
  logic        interrupt_in = 1'b0;
  logic [10:0] target_in   = 11'h000;
  logic [12:0] pc_out;
  logic [8:0]  dmem_addr_out;
  logic [7:0]  dmem_wdata_out;
  logic        dmem_wr_out;
  logic [7:0]  dmem_rdata_in;
  logic [7:0]  write_count;
  logic [31:0] rd;
  logic        err;
  int          fail_count = 0;
  int          n_compared = 0;

  pc_stack_core pc_stack_core_i (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .step_in(step_in),
    .call_in(call_in), .jump_in(jump_in), .return_in(return_in), .interrupt_in(interrupt_in),
    .target_in(target_in), .pc_out(pc_out), .dmem_addr_out(dmem_addr_out),
    .dmem_wdata_out(dmem_wdata_out), .dmem_wr_out(dmem_wr_out), .dmem_rdata_in(dmem_rdata_in));

  dmem_model dmem_model_i (.clk_in(core_clk_in), .addr_in(dmem_addr_out), .wdata_in(dmem_wdata_out),
    .wr_in(dmem_wr_out), .rdata_out(dmem_rdata_in), .write_count_out(write_count));

  initial
  begin
    forever #10 core_clk_in = ~core_clk_in;
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : cmp_val

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : cmp_bit

  // Setup then access; hold until pready is sampled high, return at the falling edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    int n;
    n = 0;
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= addr;
    pwdata_in <= {24'h0, data};
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do
    begin
      @(posedge core_clk_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 20);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(negedge core_clk_in);
    if (n >= 20)
      fail_count++;
  endtask : apb

  // One-cycle decoder pulse, then pc check once settled
  task automatic decode(input logic [4:0] kind, input logic [10:0] tgt, input logic [12:0] exp_pc);
    @(posedge core_clk_in);
    {interrupt_in, call_in, jump_in, return_in, step_in} <= kind;
    target_in <= tgt;
    @(posedge core_clk_in);
    {interrupt_in, call_in, jump_in, return_in, step_in} <= 5'h00;
    @(negedge core_clk_in);
    cmp_val("pc_out", {19'h0, exp_pc}, {19'h0, pc_out});
  endtask : decode

  initial
  begin
    #100000;
    fail_count++;
    stop_test();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge core_clk_in);
    cmp_val("pc_out", 32'h0, {19'h0, pc_out});
    cmp_bit("dmem_wr_out", 1'b0, dmem_wr_out);
    reset_n_in <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].addr, rows[i].data);
      cmp_bit("pslverr_out", rows[i].err, err);
      if (rows[i].wr)
        cmp_val("pc_out", {19'h0, rows[i].exp}, {19'h0, pc_out});
      else
        cmp_val("prdata_out", {19'h0, rows[i].exp}, rd);
    end
    cmp_val("write_count", 32'h1, {24'h0, write_count});
    apb(1'b1, a_lat, 8'h18);
    apb(1'b1, a_pcl, 8'hff);
    decode(kind_step, 11'h000, 13'h1900);
    decode(kind_call, 11'h123, 13'h1923);
    decode(kind_jump, 11'h7ff, 13'h1fff);
    apb(1'b0, a_lat, 8'h00);
    cmp_val("latch", 32'h18, rd);
    decode(kind_ret, 11'h000, 13'h1901);
    apb(1'b1, a_lat, 8'h00);
    decode(kind_jump, 11'h055, 13'h0055);
    for (int k = 1; k <= 9; k++)
      decode(kind_call, 11'(k), 13'(k));
    for (int k = 9; k >= 2; k--)
      decode(kind_ret, 11'h000, 13'(k));
    decode(kind_ret, 11'h000, 13'h0009);
    decode(kind_irq, 11'h000, pc_stack_pkg::INT_VECTOR);
    decode(kind_ret, 11'h000, 13'h0009);
    decode(kind_irq | kind_ret, 11'h000, pc_stack_pkg::INT_VECTOR);
    decode(kind_ret, 11'h000, 13'h0009);
    // Call and return on consecutive edges
    @(posedge core_clk_in);
    call_in <= 1'b1;
    target_in <= 11'h0aa;
    @(posedge core_clk_in);
    call_in <= 1'b0;
    return_in <= 1'b1;
    @(posedge core_clk_in);
    return_in <= 1'b0;
    @(negedge core_clk_in);
    cmp_val("pc_out", 32'h000a, {19'h0, pc_out});
    apb(1'b1, a_lat, 8'h1f);
    apb(1'b1, a_pcl, 8'h77);
    cmp_val("pc_out", 32'h1f77, {19'h0, pc_out});
    @(posedge core_clk_in);
    reset_n_in <= 1'b0;
    @(negedge core_clk_in);
    cmp_val("pc_out", 32'h0, {19'h0, pc_out});
    repeat (2) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    apb(1'b1, a_pcl, 8'h12);
    cmp_val("pc_out", 32'h12, {19'h0, pc_out});
    stop_test();
  end

endmodule : tb_program_counter_stack_indirect

// [core/pc_stack_core.sv]
// Program counter, circular return stack and indirect data pointer of an 8-bit core.
// Assumes an APB master on core_clk_in and a data memory with combinational read.
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps

module pc_stack_core
(
  input  wire logic        core_clk_in,      // Core clock, 50 MHz
  input  wire logic        reset_n_in,       // Asynchronous reset, active low
  input  wire logic        psel_in,          // APB select
  input  wire logic        penable_in,       // APB enable
  input  wire logic        pwrite_in,        // APB direction, high for write
  input  wire logic [7:0]  paddr_in,         // APB byte address
  input  wire logic [31:0] pwdata_in,        // APB write data
  output logic      [31:0] prdata_out,       // APB read data
  output logic             pready_out,       // APB ready
  output logic             pslverr_out,      // APB error for unmapped address
  input  wire logic        step_in,          // Advance to next instruction
  input  wire logic        call_in,          // Subroutine call
  input  wire logic        jump_in,          // Unconditional jump instruction
  input  wire logic        return_in,        // Any of the three return instructions
  input  wire logic        interrupt_in,     // Branch to interrupt vector
  input  wire logic [10:0] target_in,        // Call and jump target field
  output logic      [12:0] pc_out,           // Program counter
  output logic      [8:0]  dmem_addr_out,    // Indirect data address
  output logic      [7:0]  dmem_wdata_out,   // Indirect write data
  output logic             dmem_wr_out,      // Indirect write strobe
  input  wire logic [7:0]  dmem_rdata_in     // Data at dmem_addr_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [12:0] pc_r;
  logic [7:0]  latch_r;
  logic [7:0]  pointer_r;
  logic        bank_r;
  logic [2:0]  sp_r;
  logic [12:0] stack_r [pc_stack_pkg::STACK_DEPTH];
  logic [31:0] prdata_r;
  logic [8:0]  wr_addr_r;
  logic [7:0]  wr_data_r;
  logic        wr_r;
  logic        first_r;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic setup;
  logic access;
  logic hit_pcl;
  logic hit_latch;
  logic hit_window;
  logic hit_pointer;
  logic hit_bank;
  logic mapped;
  logic wr_access;
  logic pcl_wr;
  logic self_point;

  assign setup       = psel_in & ~penable_in;
  assign access      = psel_in & penable_in;
  assign hit_pcl     = (paddr_in == pc_stack_pkg::OFS_PCL);
  assign hit_latch   = (paddr_in == pc_stack_pkg::OFS_LATCH);
  assign hit_window  = (paddr_in == pc_stack_pkg::OFS_WINDOW);
  assign hit_pointer = (paddr_in == pc_stack_pkg::OFS_POINTER);
  assign hit_bank    = (paddr_in == pc_stack_pkg::OFS_BANK);
  assign mapped      = hit_pcl | hit_latch | hit_window | hit_pointer | hit_bank;
  assign wr_access   = access & pwrite_in & mapped;
  assign pcl_wr      = wr_access & hit_pcl;
  assign self_point  = (pointer_r == pc_stack_pkg::SELF_POINTER);

  assign pready_out  = 1'b1;
  assign pslverr_out = access & ~mapped;
  assign prdata_out  = prdata_r;

  // ----------------------------------------------------------------------
  // Sequencing events, interrupt first
  // ----------------------------------------------------------------------
  logic        int_evt;
  logic        call_evt;
  logic        jump_evt;
  logic        ret_evt;
  logic        push_evt;
  logic [12:0] push_val;
  logic [2:0]  sp_dec;

  assign int_evt  = interrupt_in;
  assign call_evt = call_in & ~interrupt_in;
  assign jump_evt = jump_in & ~interrupt_in & ~call_in;
  assign ret_evt  = return_in & ~interrupt_in & ~call_in & ~jump_in;
  assign push_evt = int_evt | call_evt;
  assign push_val = int_evt ? pc_r : 13'(pc_r + 13'h0001);
  assign sp_dec   = 3'(sp_r - 3'h1);

  // ----------------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pc_r <= pc_stack_pkg::PC_RESET;
    end
    else if (int_evt)
    begin
      pc_r <= pc_stack_pkg::INT_VECTOR;
    end
    else if (call_evt || jump_evt)
    begin
      pc_r <= {latch_r[pc_stack_pkg::LATCH_PAGE_HI:pc_stack_pkg::LATCH_PAGE_LO], target_in};
    end
    else if (ret_evt)
    begin
      pc_r <= stack_r[sp_dec];
    end
    else if (pcl_wr)
    begin
      pc_r <= {latch_r[pc_stack_pkg::UPPER_W-1:0], pwdata_in[7:0]};
    end
    else if (step_in)
    begin
      pc_r <= 13'(pc_r + 13'h0001);
    end
  end

  assign pc_out = pc_r;

  // ----------------------------------------------------------------------
  // Return stack, circular with no flags
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sp_r <= pc_stack_pkg::SP_RESET;
    end
    else if (push_evt)
    begin
      sp_r <= 3'(sp_r + 3'h1);
    end
    else if (ret_evt)
    begin
      sp_r <= sp_dec;
    end
  end

  for (genvar g = 0; g < pc_stack_pkg::STACK_DEPTH; g++)
  begin : g_stack
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
      if (!reset_n_in)
      begin
        stack_r[g] <= pc_stack_pkg::PC_RESET;
      end
      else if (push_evt && (sp_r == 3'(g)))
      begin
        stack_r[g] <= push_val;
      end
    end
  end

  // ----------------------------------------------------------------------
  // High latch, pointer and bank bit
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      latch_r <= pc_stack_pkg::LATCH_RESET;
    end
    else if (wr_access && hit_latch)
    begin
      latch_r <= pwdata_in[7:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pointer_r <= pc_stack_pkg::POINTER_RESET;
    end
    else if (wr_access && hit_pointer)
    begin
      pointer_r <= pwdata_in[7:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      bank_r <= pc_stack_pkg::BANK_RESET;
    end
    else if (wr_access && hit_bank)
    begin
      bank_r <= pwdata_in[pc_stack_pkg::BANK_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb
  begin
    rd_byte = pc_stack_pkg::ZERO_BYTE;
    if (hit_pcl)
    begin
      rd_byte = pc_r[7:0];
    end
    else if (hit_latch)
    begin
      rd_byte = latch_r;
    end
    else if (hit_window)
    begin
      rd_byte = self_point ? pc_stack_pkg::ZERO_BYTE : dmem_rdata_in;
    end
    else if (hit_pointer)
    begin
      rd_byte = pointer_r;
    end
    else if (hit_bank)
    begin
      rd_byte = {7'h00, bank_r};
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      prdata_r <= 32'h0000_0000;
    end
    else if (setup && !pwrite_in)
    begin
      prdata_r <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------------
  // Indirect data path
  // ----------------------------------------------------------------------
  assign dmem_addr_out  = wr_r ? wr_addr_r : {bank_r, pointer_r};
  assign dmem_wdata_out = wr_data_r;
  assign dmem_wr_out    = wr_r;

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wr_r      <= 1'b0;
      wr_addr_r <= 9'h000;
      wr_data_r <= 8'h00;
    end
    else
    begin
      wr_r <= wr_access && hit_window && !self_point;
      if (wr_access && hit_window)
      begin
        wr_addr_r <= {bank_r, pointer_r};
        wr_data_r <= pwdata_in[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // First cycle after reset, for checking only
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      first_r <= 1'b1;
    end
    else
    begin
      first_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_reset_upper;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    first_r |-> (pc_r[12:8] == 5'h00);
  endproperty
  a_reset_upper: assert property (p_reset_upper) else $error("Upper bits not cleared by reset");

  property p_pcl_write;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (pcl_wr && !interrupt_in && !call_in && !jump_in && !return_in)
      |=> (pc_r == {$past(latch_r[4:0]), $past(pwdata_in[7:0])});
  endproperty
  a_pcl_write: assert property (p_pcl_write) else $error("Low byte write loaded wrong counter");

  property p_call_target;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (call_evt || jump_evt) |=> (pc_r == {$past(latch_r[4:3]), $past(target_in)});
  endproperty
  a_call_target: assert property (p_call_target) else $error("Call or jump target wrong");

  property p_call_return;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (call_evt ##1 (ret_evt && !push_evt)) |=> (pc_r == 13'($past(pc_r, 2) + 13'h0001));
  endproperty
  a_call_return: assert property (p_call_return) else $error("Return did not restore call address");

  property p_int_vector;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    int_evt |=> (pc_r == pc_stack_pkg::INT_VECTOR) && (stack_r[$past(sp_r)] == $past(pc_r));
  endproperty
  a_int_vector: assert property (p_int_vector) else $error("Interrupt push or vector wrong");

  property p_latch_stable;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    ((push_evt || ret_evt) && !(wr_access && hit_latch)) |=> $stable(latch_r);
  endproperty
  a_latch_stable: assert property (p_latch_stable) else $error("Stack action changed high latch");

  property p_sp_wrap;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    push_evt |=> (sp_r == 3'($past(sp_r) + 3'h1));
  endproperty
  a_sp_wrap: assert property (p_sp_wrap) else $error("Stack pointer did not wrap by one");

  property p_self_read;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (setup && !pwrite_in && hit_window && self_point) |=> (prdata_out == 32'h0000_0000);
  endproperty
  a_self_read: assert property (p_self_read) else $error("Self indirect read not zero");

  property p_self_write;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (wr_access && hit_window) |=> (dmem_wr_out == !$past(self_point))
      && (!dmem_wr_out || dmem_addr_out == {$past(bank_r), $past(pointer_r)});
  endproperty
  a_self_write: assert property (p_self_write) else $error("Indirect write wrong");

  property p_unmapped;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (access && !mapped) |-> pslverr_out ##1 $stable(latch_r) && $stable(pointer_r);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped access not refused");

  c_call_return: cover property (@(posedge core_clk_in) disable iff (!reset_n_in) call_evt ##[1:20] ret_evt);
  c_interrupt:   cover property (@(posedge core_clk_in) disable iff (!reset_n_in) int_evt);
  c_stack_wrap:  cover property (@(posedge core_clk_in) disable iff (!reset_n_in) push_evt && sp_r == 3'h7);
  c_window_wr:   cover property (@(posedge core_clk_in) disable iff (!reset_n_in) dmem_wr_out);

endmodule : pc_stack_core

// [core/pc_stack_pkg.sv]
// Constants for the program sequencer, return stack and indirect pointer.
// Assumes a 32-bit APB register port and an 8-bit data memory on the core clock.
package pc_stack_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int PC_W        = 13;
  localparam int UPPER_W     = 5;
  localparam int DATA_W      = 8;
  localparam int DADDR_W     = 9;
  localparam int TARGET_W    = 11;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W        = 3;
  localparam int APB_AW      = 8;
  localparam int APB_DW      = 32;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_PCL     = 8'h00;
  localparam logic [7:0] OFS_LATCH   = 8'h04;
  localparam logic [7:0] OFS_WINDOW  = 8'h08;
  localparam logic [7:0] OFS_POINTER = 8'h0c;
  localparam logic [7:0] OFS_BANK    = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int LATCH_PAGE_HI = 4;
  localparam int LATCH_PAGE_LO = 3;
  localparam int BANK_BIT      = 0;

  // ----------------------------------------------------------------------
  // Values after reset and fixed values
  // ----------------------------------------------------------------------
  localparam logic [12:0] PC_RESET      = 13'h0000;
  localparam logic [12:0] INT_VECTOR    = 13'h0004;
  localparam logic [7:0]  LATCH_RESET   = 8'h00;
  localparam logic [7:0]  POINTER_RESET = 8'h00;
  localparam logic        BANK_RESET    = 1'b0;
  localparam logic [2:0]  SP_RESET      = 3'h0;
  localparam logic [7:0]  SELF_POINTER  = 8'h00;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;

endpackage : pc_stack_pkg
